//--- shared/ifp_pkg.sv
// Purpose: shared constants and types for the flash programming control block
// Assumes: 8-bit registers, one per 32-bit Wishbone word, low byte lane
// Notes:   offsets are byte addresses
package ifp_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MAIN_CTRL  = 8'h00;
  localparam logic [7:0] OFS_RST_PAT    = 8'h04;
  localparam logic [7:0] OFS_BUF_CLR    = 8'h08;
  localparam logic [7:0] OFS_ADDR_LOW   = 8'h0C;
  localparam logic [7:0] OFS_ADDR_HIGH  = 8'h10;
  localparam logic [7:0] OFS_DATA_BASE  = 8'h14;
  localparam logic [7:0] OFS_DATA_LAST  = 8'h30;

  // main control field positions
  localparam int unsigned BIT_ENABLED   = 7;
  localparam int unsigned BIT_MODE_HI   = 6;
  localparam int unsigned BIT_MODE_LO   = 4;
  localparam int unsigned BIT_TRIGGER   = 3;
  localparam int unsigned BIT_WRITE_GO  = 2;
  localparam int unsigned BIT_READ_EN   = 1;
  localparam int unsigned BIT_READ_GO   = 0;

  // reset values and special values
  localparam logic [7:0] RST_VAL        = 8'h00;
  localparam logic [7:0] CHIP_RST_KEY   = 8'h55;
  localparam logic [15:0] BUF_CLR_VAL   = 16'h0000;

  // enable pattern for word1 low .. word3 high
  localparam logic [47:0] ENABLE_KEY    = 48'h40_C3_09_0D_04_00;

  // timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned PROC_TIME_US   = 64;
  localparam int unsigned PROC_CYC       = PROC_TIME_US * CLK_MHZ;
  localparam int unsigned WRITE_TIME_US  = 2200;
  localparam int unsigned WRITE_CYC      = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned READ_CYC       = 4;

  typedef enum logic [2:0] {
    MODE_WRITE  = 3'b000,
    MODE_ERASE  = 3'b001,
    MODE_READ   = 3'b011,
    MODE_ENABLE = 3'b110
  } ifp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUSY  = 2'b01,
    ST_CLEAR = 2'b10
  } ifp_state_t;

  // flash operation request to the array
  typedef struct packed {
    logic       erase;
    logic       write;
    logic       read;
  } ifp_op_t;

endpackage : ifp_pkg

//--- core/ifp_ctrl.sv
// Purpose: in-application flash programming register block and sequencer
// Assumes: classic Wishbone slave, 8-bit registers in the low byte lane
// Notes:   flash array sits outside; this block drives its requests
// Contract
// - processor is held while a flash read, write or erase runs
// - reset pattern register resets to zero; writing 55h resets the chip
// - buffer clear bit starts a clear; hardware drops it when done
// - buffer clear bits 7..1 read zero; only bit 0 writable, resets 0
// - address low byte plus variant-width high bits; unused read zero
// - writing word0 low only stores it, nothing enters the buffer
// - writing word0 high with the enabled flag set loads the word into the buffer, then bumps address
// - words one to three are read/write byte pairs resetting to zero
// - successful enable procedure sets the enabled flag; needed for erase/write
// - erase and write are refused until the enable procedure succeeds
// - mode codes: write 000, erase 001, read 011, enable 110
// - enable needs 00,04,0D,09,C3,40 in word1..3 bytes before timeout
// - software may clear the enabled flag; writing one does nothing
// - buffer address stops at the page's last word
`timescale 1ns/1ps
`default_nettype none
module ifp_ctrl #(
  parameter int unsigned ADDR_HI_W = 6,
  parameter int unsigned PAGE_W    = 6,
  parameter int unsigned PROC_CNT  = ifp_pkg::PROC_CYC,
  parameter int unsigned WRITE_CNT = ifp_pkg::WRITE_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // flash array side
  input  wire logic        flash_done,
  input  wire logic [15:0] flash_rdata,
  output ifp_pkg::ifp_op_t flash_op,
  output logic [15:0]      flash_word,
  // system
  output logic             cpu_hold,
  output logic             chip_reset_req
);

  localparam int unsigned AW = 8 + ADDR_HI_W;
  localparam int unsigned PW = 1 << PAGE_W;
  localparam int unsigned CW = 32;

  // register state
  logic [7:0]            main_flash_control, next_main;
  logic [7:0]            chip_reset_pattern, next_rst_pat;
  logic                  buffer_clear_go, next_clr_go;
  logic [AW-1:0]         flash_addr, next_addr;
  logic [7:0]            data_reg [8];
  logic [7:0]            next_data [8];
  logic [15:0]           wbuf [PW];
  logic [15:0]           next_wbuf [PW];
  logic [CW-1:0]         proc_cnt, next_proc_cnt;
  logic [CW-1:0]         op_cnt, next_op_cnt;
  logic [PAGE_W-1:0]     clr_idx, next_clr_idx;
  ifp_pkg::ifp_state_t   state, next_state;
  logic                  ack, next_ack;
  logic [31:0]           rdat, next_rdat;
  logic                  hold, next_hold;
  logic                  crst, next_crst;
  ifp_pkg::ifp_op_t      op, next_op;
  logic [15:0]           fword, next_fword;

  logic                  acc, wr;
  logic                  en_keep, en_set;
  logic [7:0]            wbyte, rbyte;
  logic [2:0]            mode;
  logic [47:0]           key_bytes;
  logic [PAGE_W-1:0]     page_idx;

  assign acc      = wb_cyc_i && wb_stb_i && !ack;
  assign wr       = acc && wb_we_i && wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign mode     = main_flash_control[ifp_pkg::BIT_MODE_HI:
                                       ifp_pkg::BIT_MODE_LO];
  assign page_idx = flash_addr[PAGE_W-1:0];
  assign key_bytes = {data_reg[7], data_reg[6], data_reg[5],
                      data_reg[4], data_reg[3], data_reg[2]};

  // read mux, reserved bits zero
  always_comb begin
    rbyte = 8'h00;
    unique case (wb_adr_i)
      ifp_pkg::OFS_MAIN_CTRL: rbyte = main_flash_control;
      ifp_pkg::OFS_RST_PAT:   rbyte = chip_reset_pattern;
      ifp_pkg::OFS_BUF_CLR:   rbyte = {7'h00, buffer_clear_go};
      ifp_pkg::OFS_ADDR_LOW:  rbyte = flash_addr[7:0];
      ifp_pkg::OFS_ADDR_HIGH: rbyte = 8'(flash_addr[AW-1:8]);
      default: begin
        if (wb_adr_i >= ifp_pkg::OFS_DATA_BASE &&
            wb_adr_i <= ifp_pkg::OFS_DATA_LAST &&
            wb_adr_i[1:0] == 2'b00)
          rbyte = data_reg[3'((wb_adr_i - ifp_pkg::OFS_DATA_BASE) >> 2)];
      end
    endcase
  end

  // next-state: registers, sequencer and bus answer
  always_comb begin
    next_main     = main_flash_control;
    next_rst_pat  = chip_reset_pattern;
    next_clr_go   = buffer_clear_go;
    next_addr     = flash_addr;
    next_data     = data_reg;
    next_wbuf     = wbuf;
    next_proc_cnt = proc_cnt;
    next_op_cnt   = op_cnt;
    next_clr_idx  = clr_idx;
    next_state    = state;
    next_ack      = acc;
    next_rdat     = acc ? {24'h000000, rbyte} : 32'h0000_0000;
    next_crst     = 1'b0;
    next_op       = '0;
    next_fword    = fword;
    en_keep       = 1'b0;
    en_set        = 1'b0;

    // enable procedure timer
    if (main_flash_control[ifp_pkg::BIT_TRIGGER]) begin
      if (key_bytes == ifp_pkg::ENABLE_KEY &&
          mode == ifp_pkg::MODE_ENABLE) begin
        next_main[ifp_pkg::BIT_ENABLED] = 1'b1;
        next_main[ifp_pkg::BIT_TRIGGER] = 1'b0;
      end else if (proc_cnt == CW'(PROC_CNT - 1)) begin
        next_main[ifp_pkg::BIT_TRIGGER] = 1'b0;
      end else begin
        next_proc_cnt = proc_cnt + 1'b1;
      end
    end else begin
      next_proc_cnt = '0;
    end

    // software writes
    if (wr) begin
      unique case (wb_adr_i)
        ifp_pkg::OFS_MAIN_CTRL: begin
          // enabled flag: clear only, one ignored; a key match in
          // the same cycle still sets it, the hardware set wins
          en_keep = main_flash_control[ifp_pkg::BIT_ENABLED] &
                    wbyte[ifp_pkg::BIT_ENABLED];
          en_set  = next_main[ifp_pkg::BIT_ENABLED] &
                    ~main_flash_control[ifp_pkg::BIT_ENABLED];
          next_main = {en_keep | en_set, wbyte[6:0]};
          if (wbyte[ifp_pkg::BIT_TRIGGER] &&
              !main_flash_control[ifp_pkg::BIT_TRIGGER])
            next_proc_cnt = '0;
        end
        ifp_pkg::OFS_RST_PAT: begin
          next_rst_pat = wbyte;
          next_crst    = (wbyte == ifp_pkg::CHIP_RST_KEY);
        end
        ifp_pkg::OFS_BUF_CLR:
          if (wbyte[0] && state == ifp_pkg::ST_IDLE) begin
            next_clr_go  = 1'b1;
            next_clr_idx = '0;
            next_state   = ifp_pkg::ST_CLEAR;
          end
        ifp_pkg::OFS_ADDR_LOW:  next_addr[7:0] = wbyte;
        ifp_pkg::OFS_ADDR_HIGH:
          next_addr[AW-1:8] = wbyte[ADDR_HI_W-1:0];
        default: begin
          if (wb_adr_i >= ifp_pkg::OFS_DATA_BASE &&
              wb_adr_i <= ifp_pkg::OFS_DATA_LAST &&
              wb_adr_i[1:0] == 2'b00)
            next_data[3'((wb_adr_i - ifp_pkg::OFS_DATA_BASE) >> 2)] =
              wbyte;
          if (wb_adr_i == ifp_pkg::OFS_DATA_BASE + 8'h04 &&
              main_flash_control[ifp_pkg::BIT_ENABLED]) begin
            next_wbuf[page_idx] = {wbyte, data_reg[0]};
            if (page_idx != PAGE_W'(PW - 1))
              next_addr = flash_addr + 1'b1;
          end
        end
      endcase
    end

    // operation sequencer
    unique case (state)
      ifp_pkg::ST_IDLE: begin
        if (main_flash_control[ifp_pkg::BIT_WRITE_GO]) begin
          if (main_flash_control[ifp_pkg::BIT_ENABLED] &&
              (mode == ifp_pkg::MODE_WRITE ||
               mode == ifp_pkg::MODE_ERASE)) begin
            next_state   = ifp_pkg::ST_BUSY;
            next_op_cnt  = '0;
            next_op.write = (mode == ifp_pkg::MODE_WRITE);
            next_op.erase = (mode == ifp_pkg::MODE_ERASE);
            next_fword   = wbuf[0];
          end else begin
            next_main[ifp_pkg::BIT_WRITE_GO] = 1'b0;
          end
        end else if (main_flash_control[ifp_pkg::BIT_READ_GO]) begin
          if (main_flash_control[ifp_pkg::BIT_READ_EN] &&
              mode == ifp_pkg::MODE_READ) begin
            next_state  = ifp_pkg::ST_BUSY;
            next_op_cnt = '0;
            next_op.read = 1'b1;
          end else begin
            next_main[ifp_pkg::BIT_READ_GO] = 1'b0;
          end
        end
      end
      ifp_pkg::ST_BUSY: begin
        next_op_cnt = op_cnt + 1'b1;
        if (flash_done ||
            (main_flash_control[ifp_pkg::BIT_READ_GO] &&
             op_cnt >= CW'(ifp_pkg::READ_CYC - 1)) ||
            op_cnt >= CW'(WRITE_CNT - 1)) begin
          next_state = ifp_pkg::ST_IDLE;
          if (main_flash_control[ifp_pkg::BIT_READ_GO]) begin
            next_data[0] = flash_rdata[7:0];
            next_data[1] = flash_rdata[15:8];
          end else if (mode == ifp_pkg::MODE_WRITE) begin
            // a finished write empties the whole buffer
            for (int i = 0; i < PW; i++)
              next_wbuf[i] = ifp_pkg::BUF_CLR_VAL;           // auto clear
          end
          next_main[ifp_pkg::BIT_WRITE_GO] = 1'b0;
          next_main[ifp_pkg::BIT_READ_GO]  = 1'b0;
        end
      end
      ifp_pkg::ST_CLEAR: begin
        // one buffer word per cycle, busy bit drops at the last
        next_wbuf[clr_idx] = ifp_pkg::BUF_CLR_VAL;
        next_clr_idx       = clr_idx + 1'b1;
        if (clr_idx == PAGE_W'(PW - 1)) begin
          next_clr_go = 1'b0;
          next_state  = ifp_pkg::ST_IDLE;
        end
      end
      default: next_state = ifp_pkg::ST_IDLE;
    endcase

    // processor held while an operation runs
    next_hold = (next_state == ifp_pkg::ST_BUSY);
  end

  // register everything
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_flash_control <= ifp_pkg::RST_VAL;
      chip_reset_pattern <= ifp_pkg::RST_VAL;
      buffer_clear_go    <= 1'b0;
      flash_addr         <= '0;
      for (int i = 0; i < 8; i++)
        data_reg[i] <= ifp_pkg::RST_VAL;
      for (int i = 0; i < PW; i++)
        wbuf[i] <= ifp_pkg::BUF_CLR_VAL;
      proc_cnt <= '0;
      op_cnt   <= '0;
      clr_idx  <= '0;
      state    <= ifp_pkg::ST_IDLE;
      ack      <= 1'b0;
      rdat     <= 32'h0000_0000;
      hold     <= 1'b0;
      crst     <= 1'b0;
      op       <= '0;
      fword    <= 16'h0000;
    end else begin
      main_flash_control <= next_main;
      chip_reset_pattern <= next_rst_pat;
      buffer_clear_go    <= next_clr_go;
      flash_addr         <= next_addr;
      data_reg           <= next_data;
      wbuf               <= next_wbuf;
      proc_cnt           <= next_proc_cnt;
      op_cnt             <= next_op_cnt;
      clr_idx            <= next_clr_idx;
      state              <= next_state;
      ack                <= next_ack;
      rdat               <= next_rdat;
      hold               <= next_hold;
      crst               <= next_crst;
      op                 <= next_op;
      fword              <= next_fword;
    end
  end

  // outputs straight from flops
  assign wb_ack_o       = ack;
  assign wb_dat_o       = rdat;
  assign cpu_hold       = hold;
  assign chip_reset_req = crst;
  assign flash_op       = op;
  assign flash_word     = fword;

endmodule : ifp_ctrl
`default_nettype wire

//--- testbench/ifp_flash_model.sv
// Purpose: flash array stand-in answering start pulses with done and data
// Assumes: one start pulse per operation
// Notes:   slow selects a long erase/write time; erase reads blank
`timescale 1ns/1ps
`default_nettype none
module ifp_flash_model #(
  parameter logic [15:0] RWORD = 16'hA5C3
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // array side
  input  wire ifp_pkg::ifp_op_t op,
  input  wire logic             slow,
  output logic                  done,
  output logic [15:0]           rdata
);
  logic [4:0] cnt;
  logic [3:0] rcnt;
  logic       tog;
  logic       blank;
  // erase/write timer and read data window
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt  <= 5'h00;
      rcnt <= 4'h0;
      tog  <= 1'b0;
      blank <= 1'b0;
    end else begin
      tog  <= ~tog;
      blank <= op.erase | (blank & ~op.write);
      cnt  <= (op.erase | op.write) ? (slow ? 5'h10 : 5'h03) :
              (cnt != 5'h00) ? cnt - 5'h01 : 5'h00;
      rcnt <= op.read ? 4'h8 : (rcnt != 4'h0) ? rcnt - 4'h1 : 4'h0;
    end
  end
  assign done  = (cnt == 5'h01);
  // outside the read window the data keeps moving
  assign rdata = (rcnt != 4'h0) ? (blank ? 16'h0000 : RWORD) :
                 ~RWORD ^ {16{tog}};
endmodule : ifp_flash_model
`default_nettype wire

//--- testbench/ifp_ctrl_props.sv
// Purpose: port-level checks of the flash programming control block
// Assumes: classic single-cycle Wishbone master
// Notes:   bound into every ifp_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module ifp_ctrl_chk #(
  parameter int unsigned ADDR_HI_W = 6
) (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             nrst,
  // wishbone
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // flash and system
  input wire ifp_pkg::ifp_op_t flash_op,
  input wire logic             cpu_hold,
  input wire logic             chip_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic take;
  logic wr_key;
  logic rd_ack;
  // decoded bus events
  assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_key = take & wb_we_i & wb_sel_i[0] &
                  (wb_adr_i == ifp_pkg::OFS_RST_PAT) &
                  (wb_dat_i[7:0] == ifp_pkg::CHIP_RST_KEY);
  assign rd_ack = wb_ack_o & ~wb_we_i;
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_lat; take |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack missing");
  property p_idle_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_idle_dat: assert property (p_idle_dat) else $error("data without ack");
  property p_key_rst; wr_key |-> ##[1:2] chip_reset_req; endproperty
  a_key_rst: assert property (p_key_rst) else $error("no reset pulse");
  property p_rst_cause;
    chip_reset_req |-> $past(wr_key) || $past(wr_key, 2);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("stray reset");
  property p_rst_pulse; chip_reset_req |=> !chip_reset_req; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset too long");
  property p_op_hold; flash_op != 3'b000 |-> ##[0:1] cpu_hold; endproperty
  a_op_hold: assert property (p_op_hold) else $error("cpu not held");
  property p_op_pulse; flash_op != 3'b000 |=> flash_op == 3'b000; endproperty
  a_op_pulse: assert property (p_op_pulse) else $error("op start too long");
  property p_clr_rd;
    rd_ack && wb_adr_i == ifp_pkg::OFS_BUF_CLR |-> wb_dat_o[7:1] == 7'h00;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear bits set");
  property p_hi_rd;
    rd_ack && wb_adr_i == ifp_pkg::OFS_ADDR_HIGH |->
      wb_dat_o[7:ADDR_HI_W] == '0;
  endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("unused high bits");
  c_rst: cover property (chip_reset_req);
  c_write: cover property (flash_op.write);
  c_hold: cover property ($rose(cpu_hold));
endmodule : ifp_ctrl_chk
bind ifp_ctrl ifp_ctrl_chk #(.ADDR_HI_W(ADDR_HI_W)) i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .flash_op(flash_op), .cpu_hold(cpu_hold), .chip_reset_req(chip_reset_req));
`default_nettype wire

//--- testbench/ifp_ctrl_bench.sv
// Purpose: self-checking bench for the flash programming control block
// Assumes: fixed bus latency, short timers via parameters
// Notes:   bench acts as the processor, model as the flash array
`timescale 1ns/1ps
`default_nettype none
module ifp_ctrl_bench;
  localparam int AHW = 6;
  localparam logic [15:0] RWORD = 16'h5A3C;
  localparam logic [7:0] DB = ifp_pkg::OFS_DATA_BASE;
  logic clk_sys = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic slow = 1'b0, ack, done, hold, rreq;
  logic [3:0] sel = 4'h1;
  logic [7:0] adr = 8'h00, q, lo, hi;
  logic [31:0] wdat = 32'h0, rdat;
  logic [15:0] rword, fword, cap_word;
  ifp_pkg::ifp_op_t fop, last_op;
  int failures = 0, check_count = 0, cyc_n = 0, op_cnt = 0, rst_cnt = 0;
  // clock
  always #5 clk_sys = ~clk_sys;
  ifp_ctrl #(.ADDR_HI_W(AHW), .PROC_CNT(200), .WRITE_CNT(200)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .flash_done(done),
    .flash_rdata(rword), .flash_op(fop), .flash_word(fword),
    .cpu_hold(hold), .chip_reset_req(rreq));
  ifp_flash_model #(.RWORD(RWORD)) i_far (.clk_sys(clk_sys), .nrst(nrst),
    .op(fop), .slow(slow), .done(done), .rdata(rword));
  // op and reset pulse monitor, timeout
  always @(posedge clk_sys) begin
    cyc_n++;
    if ((|fop) === 1'b1) begin
      op_cnt++;
      last_op = fop;
      cap_word = fword;
    end
    if (rreq === 1'b1) rst_cnt++;
    if (cyc_n == 20000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [7:0] hi_mask(input logic [7:0] d);
    return d & 8'((9'h001 << AHW) - 9'h001);
  endfunction : hi_mask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk(8'h00, 8'hFF);
  endtask : wb
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd_chk
  task automatic wait_hold(input logic lvl);
    int n;
    n = 0;
    // bound below the internal write timer: the array's done must end it
    while (hold !== lvl && n < 100) begin @(posedge clk_sys); n++; end
    chk({7'h00, hold}, {7'h00, lvl});
  endtask : wait_hold
  task automatic run_op(input logic [7:0] c, input logic [2:0] e);
    int k;
    k = op_cnt;
    wb(1'b1, 8'h00, c);
    wait_hold(1'b1);
    wait_hold(1'b0);
    chk(8'(op_cnt - k), 8'h01);
    chk({5'h00, last_op}, {5'h00, e});
  endtask : run_op
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    logic [7:0] a;
    int k;
    void'($urandom(17));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 14; i++) rd_chk(i == 13 ? 8'h40 : 8'(4 * i), 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = DB + 8'(8 + 4 * i);
      lo = 8'($urandom);
      wb(1'b1, a, lo);
      rd_chk(a, lo);
    end
    wb(1'b1, ifp_pkg::OFS_ADDR_HIGH, 8'hFF);
    rd_chk(ifp_pkg::OFS_ADDR_HIGH, hi_mask(8'hFF));
    wb(1'b1, ifp_pkg::OFS_BUF_CLR, 8'hFE);
    rd_chk(ifp_pkg::OFS_BUF_CLR, 8'h00);
    wb(1'b1, ifp_pkg::OFS_ADDR_HIGH, 8'h00);
    $display("test registers done");
    wb(1'b1, 8'h00, 8'h80);
    rd_chk(8'h00, 8'h00);
    k = op_cnt;
    wb(1'b1, 8'h00, 8'h04);
    repeat (10) @(posedge clk_sys);
    chk(8'(op_cnt - k), 8'h00);
    rd_chk(8'h00, 8'h00);
    wb(1'b1, 8'h00, 8'h60);
    // procedure timer runs out with no key written
    wb(1'b1, 8'h00, 8'h68);
    repeat (210) @(posedge clk_sys);
    rd_chk(8'h00, 8'h60);
    wb(1'b1, 8'h00, 8'h68);
    for (int i = 0; i < 6; i++)
      wb(1'b1, DB + 8'(8 + 4 * i), ifp_pkg::ENABLE_KEY[8 * i +: 8]);
    rd_chk(8'h00, 8'hE0);
    $display("test enable done");
    wb(1'b1, ifp_pkg::OFS_ADDR_LOW, 8'h00);
    lo = 8'($urandom);
    hi = 8'($urandom);
    wb(1'b1, DB, lo);
    rd_chk(ifp_pkg::OFS_ADDR_LOW, 8'h00);
    wb(1'b1, DB + 8'h04, hi);
    rd_chk(ifp_pkg::OFS_ADDR_LOW, 8'h01);
    wb(1'b1, ifp_pkg::OFS_ADDR_LOW, 8'h3E);
    for (int i = 0; i < 4; i++) wb(1'b1, DB + 8'(4 * (i % 2)), 8'($urandom));
    rd_chk(ifp_pkg::OFS_ADDR_LOW, 8'h3F);
    // erase, blank check, then write the loaded page and read RWORD from the model
    slow <= 1'b1;
    run_op(8'h94, 3'b100);
    wb(1'b1, 8'h00, 8'hB2);
    run_op(8'hB3, 3'b001);
    rd_chk(DB, 8'h00);
    rd_chk(DB + 8'h04, 8'h00);
    run_op(8'h84, 3'b010);
    chk(cap_word[7:0], lo);
    chk(cap_word[15:8], hi);
    wb(1'b1, 8'h00, 8'hB2);
    run_op(8'hB3, 3'b001);
    rd_chk(DB, RWORD[7:0]);
    rd_chk(DB + 8'h04, RWORD[15:8]);
    $display("test operations done");
    wb(1'b1, ifp_pkg::OFS_ADDR_LOW, 8'h00);
    wb(1'b1, DB, 8'h11);
    wb(1'b1, DB + 8'h04, 8'h22);
    wb(1'b1, ifp_pkg::OFS_BUF_CLR, 8'h01);
    k = 0;
    do begin wb(1'b0, ifp_pkg::OFS_BUF_CLR, 8'h00); k++; end
      while (q !== 8'h00 && k < 100);
    chk(q, 8'h00);
    run_op(8'h84, 3'b010);
    chk(cap_word[7:0], ifp_pkg::BUF_CLR_VAL[7:0]);
    chk(cap_word[15:8], ifp_pkg::BUF_CLR_VAL[15:8]);
    wb(1'b1, 8'h00, 8'h00);
    rd_chk(8'h00, 8'h00);
    $display("test clear done");
    // key written with byte lane 0 off must be ignored
    sel <= 4'hE;
    wb(1'b1, ifp_pkg::OFS_RST_PAT, ifp_pkg::CHIP_RST_KEY);
    sel <= 4'h1;
    rd_chk(ifp_pkg::OFS_RST_PAT, 8'h00);
    lo = 8'($urandom);
    if (lo == ifp_pkg::CHIP_RST_KEY) lo = 8'h54;
    wb(1'b1, ifp_pkg::OFS_RST_PAT, lo);
    rd_chk(ifp_pkg::OFS_RST_PAT, lo);
    repeat (4) @(posedge clk_sys);
    chk(8'(rst_cnt), 8'h00);
    wb(1'b1, ifp_pkg::OFS_RST_PAT, ifp_pkg::CHIP_RST_KEY);
    repeat (4) @(posedge clk_sys);
    chk(8'(rst_cnt), 8'h01);
    $display("test reset pattern done");
    give_verdict();
  end
endmodule : ifp_ctrl_bench
`default_nettype wire
